// file: hdl/shreg16_pkg.sv
package shreg16_pkg;
    localparam int WORD_W = 16;
    localparam int TOP_BIT = 15;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic VARIANT_STORAGE = 1'b0;
    localparam logic VARIANT_PARALLEL = 1'b1;
endpackage

// file: hdl/sync2.sv
`timescale 1ns/10ps
// two-stage synchroniser for a group of pin levels
module sync2 #(
    parameter int W = 1
) (
    input wire logic ref_clk, // system clock
    input wire logic rst_b, // async reset, low active
    input wire logic clk_en, // freezes state while low
    input wire logic [W-1:0] d, // asynchronous levels
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            q <= '0;
        end else if (clk_en) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // sync2

// file: hdl/shreg16.sv
`timescale 1ns/10ps
// How it works
// - shift and storage registers are sixteen bits
// - chip select high ignores clocks, floats port
// - storage clear low clears storage immediately
// - write direction: port input, shift per edge
// - read direction drives bit 15 continuously
// - read, mode low: falling edge shifts up
// - read shifting recirculates bit 15 into 0
// - read, mode high: storage copied into shift
// - write, rising store clock captures shift word
// - storage outputs always show storage register
// - parallel variant: mode high loads inputs
module shreg16 #(
    parameter logic VARIANT = shreg16_pkg::VARIANT_STORAGE, // 0 storage form, 1 parallel-input form
    parameter int WIDTH = shreg16_pkg::WORD_W // word width
) (
    input wire logic ref_clk, // system clock
    input wire logic rst_b, // async reset, low active
    input wire logic clk_en, // freezes all state while low, except the async storage clear
    input wire logic chip_select_n, // chip select, low active
    input wire logic read_not_write, // high read, low write
    input wire logic shift_clock, // shift clock pin
    input wire logic storage_clear_n, // async storage clear, low active
    input wire logic mode_or_store_clock, // mode, or store clock in write
    input wire logic serial_io_in, // serial pin level
    output logic serial_io_out, // serial pin drive value
    output logic serial_io_oe, // high while driving serial pin
    input wire logic [WIDTH-1:0] parallel_inputs, // parallel data pins
    output logic [WIDTH-1:0] storage_outputs // storage register view
);
    logic [4:0] pins_s;
    logic [WIDTH-1:0] par_s;
    logic cs_n_s, rd_s, sck_s, mode_s, ser_s;
    logic sck_prev_q, mode_prev_q, clr_meta_q, clr_s_q;
    logic [WIDTH-1:0] shift_q, storage_q;
    logic sck_fall, store_rise, active;

    sync2 #(.W(5)) u_sync_ctl (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .d({~chip_select_n, read_not_write, shift_clock, mode_or_store_clock, serial_io_in}),
        .q(pins_s)
    );
    sync2 #(.W(WIDTH)) u_sync_par (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .d(parallel_inputs),
        .q(par_s)
    );
    // select travels inverted so the synchroniser's zero reset reads as deselected
    assign cs_n_s = ~pins_s[4];
    assign {rd_s, sck_s, mode_s, ser_s} = pins_s[3:0];

    // edge detectors look only at synchronised levels
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_prev_q <= 1'b0;
            mode_prev_q <= 1'b0;
        end else if (clk_en) begin
            sck_prev_q <= sck_s;
            mode_prev_q <= mode_s;
        end
    end

    assign active = !cs_n_s;
    assign sck_fall = active && sck_prev_q && !sck_s;
    assign store_rise = active && !rd_s && !mode_prev_q && mode_s
        && (VARIANT == shreg16_pkg::VARIANT_STORAGE);

    // clear level synchronised too so copy-back sees zero while clear held
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clr_meta_q <= 1'b1;
            clr_s_q <= 1'b1;
        end else if (clk_en) begin
            clr_meta_q <= storage_clear_n;
            clr_s_q <= clr_meta_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_q <= shreg16_pkg::WORD_RST;
        end else if (clk_en && sck_fall) begin
            if (!rd_s) begin
                shift_q <= {shift_q[WIDTH-2:0], ser_s};
            end else if (!mode_s) begin
                shift_q <= {shift_q[WIDTH-2:0], shift_q[WIDTH-1]};
            end else if (VARIANT == shreg16_pkg::VARIANT_STORAGE) begin
                shift_q <= clr_s_q ? storage_q : '0;
            end else begin
                shift_q <= par_s;
            end
        end
    end

    // clear acts without clock and regardless of select or enable
    always_ff @(posedge ref_clk or negedge rst_b or negedge storage_clear_n) begin
        if (!rst_b) begin
            storage_q <= shreg16_pkg::WORD_RST;
        end else if (!storage_clear_n) begin
            storage_q <= shreg16_pkg::WORD_RST;
        end else if (clk_en && store_rise) begin
            storage_q <= shift_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b or negedge storage_clear_n) begin
        if (!rst_b) begin
            storage_outputs <= shreg16_pkg::WORD_RST;
        end else if (!storage_clear_n) begin
            storage_outputs <= shreg16_pkg::WORD_RST;
        end else if (clk_en) begin
            storage_outputs <= (VARIANT == shreg16_pkg::VARIANT_STORAGE) ? storage_q : '0;
        end
    end

    // registered port drive: lags the shift register by one cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_io_out <= 1'b0;
            serial_io_oe <= 1'b0;
        end else if (clk_en) begin
            serial_io_oe <= active && rd_s;
            serial_io_out <= shift_q[WIDTH-1];
        end
    end

    // read shifting rotates the word so nothing falls off the top
    property p_shift_read;
        @(posedge ref_clk) disable iff (!rst_b)
        clk_en && sck_fall && rd_s && !mode_s |=> shift_q == {$past(shift_q[WIDTH-2:0]), $past(shift_q[WIDTH-1])};
    endproperty
    read_recirculate_a: assert property (p_shift_read) else $error("read shift lost a bit");

    write_shift_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && sck_fall && !rd_s
        |=> shift_q[0] == $past(ser_s) && shift_q[WIDTH-1:1] == $past(shift_q[WIDTH-2:0]))
        else $error("serial write shift wrong");

    shift_on_fall_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && !(sck_prev_q && !sck_s)
        |=> $stable(shift_q))
        else $error("shift register moved without a falling edge");

    parallel_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && sck_fall && rd_s && mode_s && VARIANT == shreg16_pkg::VARIANT_PARALLEL
        |=> shift_q == $past(par_s))
        else $error("parallel load wrong");

    load_shows_top_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && sck_fall && rd_s && mode_s && VARIANT == shreg16_pkg::VARIANT_PARALLEL ##1 clk_en
        |=> serial_io_out == $past(par_s[WIDTH-1], 2))
        else $error("port not showing loaded top input");

    copy_back_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && sck_fall && rd_s && mode_s && clr_s_q && storage_clear_n
        && VARIANT == shreg16_pkg::VARIANT_STORAGE
        |=> shift_q == $past(storage_q))
        else $error("storage copy into shift wrong");

    // a gap in the enable must leave the shift register and port drive as they were
    freeze_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !clk_en
        |=> $stable(shift_q) && $stable(serial_io_out) && $stable(serial_io_oe))
        else $error("state moved while clock enable low");

    // port drive and deselect
    idle_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cs_n_s ##1 cs_n_s
        |=> $stable(shift_q))
        else $error("shift changed while deselected");

    float_deselect_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && cs_n_s
        |=> !serial_io_oe)
        else $error("port driven while deselected");

    float_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && active && !rd_s
        |=> !serial_io_oe)
        else $error("port driven in write direction");

    drive_top_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && active && rd_s
        |=> serial_io_oe && serial_io_out == $past(shift_q[WIDTH-1]))
        else $error("read port not showing bit 15");

    // storage register path
    clear_storage_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !storage_clear_n
        |-> storage_q == '0)
        else $error("storage not cleared");

    store_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && store_rise && storage_clear_n ##1 storage_clear_n
        |-> storage_q == $past(shift_q))
        else $error("store clock did not capture");

    store_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && rd_s && storage_clear_n ##1 storage_clear_n
        |-> $stable(storage_q))
        else $error("storage loaded in read direction");

    store_deselect_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && cs_n_s && storage_clear_n ##1 storage_clear_n
        |-> $stable(storage_q))
        else $error("storage loaded while deselected");

    storage_view_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && storage_clear_n ##1 storage_clear_n && VARIANT == shreg16_pkg::VARIANT_STORAGE
        |-> storage_outputs == $past(storage_q))
        else $error("storage outputs stale");

    cov_write: cover property (@(posedge ref_clk) sck_fall && !rd_s);
    cov_read: cover property (@(posedge ref_clk) sck_fall && rd_s && !mode_s);
    cov_load: cover property (@(posedge ref_clk) sck_fall && rd_s && mode_s);
    cov_store: cover property (@(posedge ref_clk) store_rise);
    cov_copy_clear: cover property (@(posedge ref_clk) sck_fall && rd_s && mode_s && !clr_s_q);
endmodule // shreg16

// file: sim/host_model.sv
`timescale 1ns/10ps
module host_model (
    input wire logic ref_clk, // system clock
    input wire logic dev_oe, // device drive enable on serial pin
    input wire logic dev_bit, // device drive value on serial pin
    output logic chip_select_n = 1'b1, // select, low active
    output logic read_not_write = 1'b0, // high read
    output logic shift_clock = 1'b0, // shift clock pin
    output logic storage_clear_n = 1'b1, // storage clear pin
    output logic mode_or_store_clock = 1'b0, // mode or store clock
    output logic line // resolved serial pin level
);
    logic drive_bit = 1'b0;
    logic drive_en = 1'b1;
    // an undriven pin shows the inverse of the device value, never a lucky match
    assign line = dev_oe ? dev_bit : (drive_en ? drive_bit : ~dev_bit);
    // five cycles keeps every pin phase above the three-cycle sampling window
    task automatic hold();
        repeat (5) @(posedge ref_clk);
    endtask
    // callers only move select while both clocks are low
    task automatic drive_ctl(input logic cs, input logic rd, input logic md);
        @(posedge ref_clk);
        chip_select_n <= cs;
        read_not_write <= rd;
        mode_or_store_clock <= md;
        drive_en <= !rd;
        hold();
    endtask
    task automatic tick(input logic b);
        @(posedge ref_clk);
        drive_bit <= b;
        shift_clock <= 1'b1;
        hold();
        shift_clock <= 1'b0;
        hold();
    endtask
    task automatic store();
        @(posedge ref_clk);
        mode_or_store_clock <= 1'b1;
        hold();
        mode_or_store_clock <= 1'b0;
        hold();
    endtask
    task automatic clear(input logic v);
        @(posedge ref_clk);
        storage_clear_n <= v;
        hold();
    endtask
endmodule // host_model

// file: sim/test_shreg16.sv
`timescale 1ns/10ps
module test_shreg16;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b0;
    logic cs_n, rnw, sck, clr_n, mode, line, s_out, s_oe;
    logic [15:0] stor;
    logic [15:0] par = 16'hFFFF;
    logic p_out, p_oe;
    logic [15:0] p_stor;
    int error_cnt = 0;
    int total_checks = 0;
    initial forever #5 ref_clk = ~ref_clk;
    shreg16 shreg16_inst (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .chip_select_n(cs_n),
        .read_not_write(rnw), .shift_clock(sck), .storage_clear_n(clr_n), .mode_or_store_clock(mode),
        .serial_io_in(line), .serial_io_out(s_out), .serial_io_oe(s_oe), .parallel_inputs(par),
        .storage_outputs(stor));
    // parallel-input form runs beside the storage form on the same pins
    shreg16 #(.VARIANT(shreg16_pkg::VARIANT_PARALLEL)) shreg16_par_inst (.ref_clk(ref_clk), .rst_b(rst_b),
        .clk_en(clk_en), .chip_select_n(cs_n), .read_not_write(rnw), .shift_clock(sck), .storage_clear_n(clr_n),
        .mode_or_store_clock(mode), .serial_io_in(line), .serial_io_out(p_out), .serial_io_oe(p_oe),
        .parallel_inputs(par), .storage_outputs(p_stor));
    host_model host_model_inst (.ref_clk(ref_clk), .dev_oe(s_oe), .dev_bit(s_out), .chip_select_n(cs_n),
        .read_not_write(rnw), .shift_clock(sck), .storage_clear_n(clr_n), .mode_or_store_clock(mode),
        .line(line));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic write_word(input logic [15:0] w);
        host_model_inst.drive_ctl(1'b0, 1'b0, 1'b0);
        for (int i = 15; i >= 0; i--) begin
            host_model_inst.tick(w[i]);
            check("oe in write", 16'h0000, {14'h0000, p_oe, s_oe});
        end
    endtask
    task automatic read_word(input logic [15:0] w, input logic [15:0] w2);
        host_model_inst.drive_ctl(1'b0, 1'b1, 1'b0);
        for (int i = 15; i >= 0; i--) begin
            check("serial out", {15'h0000, w[i]}, {15'h0000, s_out});
            check("parallel form serial out", {15'h0000, w2[i]}, {15'h0000, p_out});
            host_model_inst.tick(1'b0);
        end
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        clk_en <= 1'b1;
        write_word(16'hA5C3);
        host_model_inst.store();
        check("storage", 16'hA5C3, stor);
        check("parallel form storage", 16'h0000, p_stor);
        read_word(16'hA5C3, 16'hA5C3);
        read_word(16'hA5C3, 16'hA5C3);
        write_word(16'h0000);
        check("storage kept", 16'hA5C3, stor);
        par <= 16'h3C5A;
        host_model_inst.drive_ctl(1'b0, 1'b1, 1'b1);
        check("top bit before load", 16'h0000, {14'h0000, p_out, s_out});
        host_model_inst.tick(1'b0);
        read_word(16'hA5C3, 16'h3C5A);
        // shift word now differs from storage so a refused store would show
        write_word(16'h9E27);
        host_model_inst.drive_ctl(1'b1, 1'b1, 1'b0);
        check("oe deselected", 16'h0000, {14'h0000, p_oe, s_oe});
        host_model_inst.drive_ctl(1'b1, 1'b0, 1'b0);
        host_model_inst.tick(1'b1);
        host_model_inst.store();
        check("storage deselected", 16'hA5C3, stor);
        read_word(16'h9E27, 16'h9E27);
        host_model_inst.drive_ctl(1'b0, 1'b0, 1'b0);
        clk_en <= 1'b0;
        host_model_inst.tick(1'b1);
        host_model_inst.store();
        clk_en <= 1'b1;
        check("storage frozen", 16'hA5C3, stor);
        read_word(16'h9E27, 16'h9E27);
        host_model_inst.drive_ctl(1'b1, 1'b0, 1'b0);
        host_model_inst.clear(1'b0);
        check("storage cleared", 16'h0000, stor);
        host_model_inst.drive_ctl(1'b0, 1'b1, 1'b0);
        host_model_inst.drive_ctl(1'b0, 1'b1, 1'b1);
        check("top bit before cleared copy", 16'h0001, {15'h0000, s_out});
        host_model_inst.tick(1'b0);
        check("cleared copy", 16'h0000, {15'h0000, s_out});
        host_model_inst.clear(1'b1);
        print_verdict();
    end
    // whole sequence needs about 1600 cycles
    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end
endmodule // test_shreg16
